// ### verilog/lcp_policy.sv
// cache attribute policy: allocation, write and security decisions
// Contract
// - decode four attribute bits into allocate hints, cacheable, bufferable
// - cacheable with no allocate hint is outer non-cacheable
// - shareable bit gives shared behaviour only for attributes 0010 and 0011
// - shared reads cacheable no allocate, shared writes write-through
// - invalidate enable: full-line shared write hit invalidates, forwards on
// - override bit disables both shared behaviours
// - force field 00 keeps received attributes
// - force 01 never allocates writes; 10 allocates cacheable write misses
// - shareable write never takes write allocate, over any force setting; exclusive eviction miss under 00 still allocates for 0111 and 1111
// - force keeps downstream attribute, beats exclusive allocation
// - exclusive bit enables exclusive mode for 1011, 0111, 1111
// - exclusive read hit clears valid, keeps dirty, prefers eviction if dirty
// - exclusive read miss does not allocate
// - exclusive write hit sets dirty unless evict and clean
// - exclusive eviction miss allocates, dirty from clean bit
// - lines tagged nonsecure; security mismatch counts as miss
// - security mismatch read: linefill, return error, no allocation
// - control and auxiliary registers written only by secure accesses
// - non-secure maintenance leaves secure lines alone
// - secure-only aux bit gates non-secure lockdown writes
// - write-back allocating write miss goes to store buffer, allocates
`timescale 1ns/1ps
module lcp_policy (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input lcp_pkg::lcp_req_t req_i,
   input lcp_pkg::lcp_look_t look_i,
   input lcp_pkg::lcp_cfg_wr_t cfg_i,
   input wire logic lock_we_i,
   input wire logic lock_nonsecure_i,
   input wire logic maint_valid_i,
   input wire logic maint_nonsecure_i,
   input wire logic maint_line_nonsecure_i,
   input wire logic next_level_done_i,
   input wire logic next_level_sec_err_i,
   output logic req_ready_o,
   output lcp_pkg::lcp_pol_t pol_o,
   output logic [3:0] dn_cache_o,
   output logic fill_req_o,
   output logic resp_done_o,
   output logic resp_err_o,
   output logic maint_act_o,
   output logic ctrl_en_o,
   output logic [31:0] aux_o,
   output logic cfg_refused_o,
   output logic lock_grant_o
);
   import lcp_pkg::*;

   lcp_attr_t attr;
   logic outer_nc, shared_attr, wb_attr;
   logic take, shared, sec_miss, hit, excl, full_line, oc;
   logic wr_alloc, write_back;
   logic [1:0] fwa;
   lcp_pol_t pol_r, pol_nxt;
   logic [3:0] dn_r, dn_nxt;
   lcp_fill_t st_r, st_nxt;
   logic ready_r, ready_nxt, fill_r, fill_nxt;
   logic done_r, done_nxt, err_r, err_nxt, mact_r, mact_nxt;

   lcp_attr_decode u_dec (
      .cache_i(req_i.cache),
      .attr_o(attr),
      .outer_nc_o(outer_nc),
      .shared_attr_o(shared_attr),
      .wb_attr_o(wb_attr)
   );

   lcp_sec_cfg u_cfg (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .cfg_i(cfg_i),
      .lock_we_i(lock_we_i),
      .lock_nonsecure_i(lock_nonsecure_i),
      .ctrl_en_o(ctrl_en_o),
      .aux_o(aux_o),
      .cfg_refused_o(cfg_refused_o),
      .lock_grant_o(lock_grant_o)
   );

   // request classification
   always_comb begin
      take = req_i.valid && ready_r;
      fwa = aux_o[AUX_FWA_HI:AUX_FWA_LO];
      shared = req_i.share && shared_attr &&
         !aux_o[AUX_SH_OVR];
      sec_miss = look_i.hit &&
         (look_i.tag_nonsecure != req_i.nonsecure);
      hit = look_i.hit && !sec_miss;
      excl = aux_o[AUX_EXCL] && wb_attr;
      full_line = (req_i.len == LINE_LEN) && (req_i.size == LINE_SIZE) &&
         req_i.strb_all;
      write_back = attr.bufferable;
      // effective write allocate; shareable bit beats force setting
      if (req_i.share) begin
         wr_alloc = 1'b0;
      end else if (fwa == FWA_NONE) begin
         wr_alloc = 1'b0;
      end else if (fwa == FWA_ALL) begin
         wr_alloc = attr.cacheable;
      end else begin
         wr_alloc = attr.write_allocate_hint;
      end
      // outer cacheable after the force setting
      oc = attr.cacheable && (req_i.write ? (attr.read_allocate_hint ||
         wr_alloc) : !outer_nc);
   end

   // policy decision
   always_comb begin
      pol_nxt = '0;
      pol_nxt.valid = take;
      pol_nxt.hit = hit;
      pol_nxt.tag_nonsecure = req_i.nonsecure;
      pol_nxt.sec_miss = sec_miss;
      pol_nxt.unpredictable = attr.cacheable &&
         (req_i.burst == BURST_FIXED);
      dn_nxt = req_i.cache;
      if (!req_i.write) begin
         if (sec_miss) begin
            pol_nxt.fwd_next = 1'b1;
         end else if (shared) begin
            pol_nxt.fwd_next = !hit;
         end else if (oc) begin
            if (excl) begin
               pol_nxt.clear_valid = hit;
               pol_nxt.prefer_evict = hit && look_i.dirty;
               pol_nxt.fwd_next = !hit;
            end else begin
               pol_nxt.allocate = !hit && attr.read_allocate_hint;
               pol_nxt.fwd_next = !hit;
            end
         end else begin
            pol_nxt.bypass = 1'b1;
            pol_nxt.fwd_next = 1'b1;
         end
      end else if (shared) begin
         pol_nxt.fwd_next = 1'b1;
         if (aux_o[AUX_SH_INV] && full_line && hit) begin
            pol_nxt.invalidate = 1'b1;
         end else begin
            pol_nxt.store_buf = hit;
            pol_nxt.write_thru = 1'b1;
         end
         pol_nxt.unpredictable = pol_nxt.unpredictable ||
            (aux_o[AUX_SH_INV] && !full_line);
      end else if (oc) begin
         pol_nxt.store_buf = 1'b1;
         pol_nxt.write_thru = !write_back;
         pol_nxt.fwd_next = !write_back || (!hit && !wr_alloc);
         if (hit) begin
            // exclusive clean eviction keeps the dirty bit
            pol_nxt.set_dirty = write_back && !(excl && req_i.evict &&
               req_i.clean);
         end else if (excl && req_i.evict && fwa == FWA_PASS) begin
            pol_nxt.allocate = 1'b1;
            pol_nxt.alloc_dirty = !req_i.clean;
            pol_nxt.fwd_next = 1'b0;
         end else begin
            pol_nxt.allocate = wr_alloc;
            pol_nxt.alloc_dirty = wr_alloc && write_back;
         end
      end else begin
         pol_nxt.bypass = 1'b1;
         pol_nxt.fwd_next = 1'b1;
      end
      if (!take) begin
         pol_nxt = '0;
         dn_nxt = dn_r;
      end
   end

   // security mismatch linefill sequence and maintenance gate
   always_comb begin
      st_nxt = st_r;
      ready_nxt = ready_r;
      fill_nxt = 1'b0;
      done_nxt = 1'b0;
      err_nxt = 1'b0;
      mact_nxt = maint_valid_i &&
         !(maint_nonsecure_i && !maint_line_nonsecure_i);
      case (st_r)
         SF_IDLE: begin
            if (take && !req_i.write && sec_miss) begin
               fill_nxt = 1'b1;
               ready_nxt = 1'b0;
               st_nxt = SF_WAIT;
            end
         end
         SF_WAIT: begin
            if (next_level_done_i) begin
               done_nxt = 1'b1;
               err_nxt = next_level_sec_err_i;
               ready_nxt = 1'b1;
               st_nxt = SF_IDLE;
            end
         end
         default: begin
            st_nxt = SF_IDLE;
            ready_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         pol_r <= '0;
         dn_r <= 4'h0;
         st_r <= SF_IDLE;
         ready_r <= 1'b1;
         fill_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
         mact_r <= 1'b0;
      end else begin
         pol_r <= pol_nxt;
         dn_r <= dn_nxt;
         st_r <= st_nxt;
         ready_r <= ready_nxt;
         fill_r <= fill_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
         mact_r <= mact_nxt;
      end
   end

   assign pol_o = pol_r;
   assign dn_cache_o = dn_r;
   assign req_ready_o = ready_r;
   assign fill_req_o = fill_r;
   assign resp_done_o = done_r;
   assign resp_err_o = err_r;
   assign maint_act_o = mact_r;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   property p_onc_bypass;
      take && outer_nc && !req_i.share && !sec_miss &&
         (!req_i.write || fwa != FWA_ALL) |=> pol_o.bypass && !pol_o.allocate;
   endproperty
   a_onc_bypass: assert property (p_onc_bypass)
      else $error("outer non-cacheable access not bypassed");

   property p_keep_attr;
      take |=> dn_cache_o == $past(req_i.cache);
   endproperty
   a_keep_attr: assert property (p_keep_attr)
      else $error("downstream attribute altered");

   property p_share_wr;
      take && req_i.write && req_i.share |=> !pol_o.allocate;
   endproperty
   a_share_wr: assert property (p_share_wr)
      else $error("shareable write allocated");

   property p_force_none;
      take && req_i.write && fwa == FWA_NONE |=> !pol_o.allocate;
   endproperty
   a_force_none: assert property (p_force_none)
      else $error("write allocated with force setting 01");

   property p_excl_rd;
      take && excl && !req_i.write && !sec_miss |=>
         (pol_o.clear_valid == pol_o.hit) && !pol_o.allocate;
   endproperty
   a_excl_rd: assert property (p_excl_rd)
      else $error("exclusive read handled wrongly");

   property p_shared_inv;
      take && req_i.write && shared && aux_o[AUX_SH_INV] && full_line && hit
         |=> pol_o.invalidate && pol_o.fwd_next;
   endproperty
   a_shared_inv: assert property (p_shared_inv)
      else $error("full-line shared write hit not invalidated");

   property p_override;
      take && aux_o[AUX_SH_OVR] |=> !pol_o.invalidate;
   endproperty
   a_override: assert property (p_override)
      else $error("shared behaviour active under override");

   property p_sec_fill;
      take && !req_i.write && sec_miss |=>
         fill_req_o && !pol_o.allocate && !req_ready_o ##1
         !fill_req_o[*2];
   endproperty
   a_sec_fill: assert property (p_sec_fill)
      else $error("security mismatch read fill sequence wrong");

   property p_err_pass;
      st_r == SF_WAIT && next_level_done_i |=>
         resp_done_o && resp_err_o == $past(next_level_sec_err_i) &&
         req_ready_o;
   endproperty
   a_err_pass: assert property (p_err_pass)
      else $error("next level error not returned");

   property p_maint;
      maint_valid_i && maint_nonsecure_i && !maint_line_nonsecure_i
         |=> !maint_act_o;
   endproperty
   a_maint: assert property (p_maint)
      else $error("non-secure maintenance touched a secure line");

   c_excl_evict: cover property (take && req_i.write && excl &&
      req_i.evict && !look_i.hit);
   c_shared_inv: cover property (take && shared && full_line && hit &&
      req_i.write);
   c_sec_fill: cover property (fill_req_o ##[1:20] resp_done_o);
endmodule // lcp_policy

// ### verilog/lcp_pkg.sv
// package: constants and carriers for the cache attribute policy block
package lcp_pkg;

   // cache attribute bit positions
   localparam int CA_W = 4;
   localparam int CA_BUF = 0;
   localparam int CA_CACHE = 1;
   localparam int CA_RD_ALLOC = 2;
   localparam int CA_WR_ALLOC = 3;

   // attribute encodings of interest
   localparam logic [3:0] ATTR_ONC_A = 4'h2;
   localparam logic [3:0] ATTR_ONC_B = 4'h3;
   localparam logic [3:0] ATTR_WB_A = 4'hb;
   localparam logic [3:0] ATTR_WB_B = 4'h7;
   localparam logic [3:0] ATTR_WB_C = 4'hf;

   // auxiliary control fields
   localparam int AUX_W = 32;
   localparam int AUX_EXCL = 12;
   localparam int AUX_SH_INV = 13;
   localparam int AUX_SH_OVR = 22;
   localparam int AUX_FWA_LO = 23;
   localparam int AUX_FWA_HI = 24;
   localparam int AUX_LOCK_NONSEC = 26;
   localparam logic [31:0] AUX_RST = 32'h0;
   localparam logic CTRL_RST = 1'b0;
   localparam int CTRL_EN = 0;

   // force write allocate settings
   localparam logic [1:0] FWA_PASS = 2'h0;
   localparam logic [1:0] FWA_NONE = 2'h1;
   localparam logic [1:0] FWA_ALL = 2'h2;

   // burst shape of a full line: four 64-bit beats
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [7:0] LINE_LEN = 8'h03;
   localparam logic [2:0] LINE_SIZE = 3'h3;

   typedef struct packed {
      logic write_allocate_hint;
      logic read_allocate_hint;
      logic cacheable;
      logic bufferable;
   } lcp_attr_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] cache;
      logic share;
      logic evict;
      logic clean;
      logic nonsecure;
      logic [1:0] burst;
      logic [7:0] len;
      logic [2:0] size;
      logic strb_all;
   } lcp_req_t;

   typedef struct packed {
      logic hit;
      logic tag_nonsecure;
      logic dirty;
   } lcp_look_t;

   typedef struct packed {
      logic valid;
      logic bypass;
      logic hit;
      logic allocate;
      logic store_buf;
      logic write_thru;
      logic fwd_next;
      logic set_dirty;
      logic alloc_dirty;
      logic invalidate;
      logic clear_valid;
      logic prefer_evict;
      logic tag_nonsecure;
      logic sec_miss;
      logic unpredictable;
   } lcp_pol_t;

   typedef struct packed {
      logic we;
      logic sel_aux;
      logic nonsecure;
      logic [31:0] wdata;
   } lcp_cfg_wr_t;

   typedef enum logic {SF_IDLE, SF_WAIT} lcp_fill_t;

   function automatic lcp_attr_t lcp_decode(input logic [3:0] ca);
      lcp_attr_t a;
      a.write_allocate_hint = ca[CA_WR_ALLOC];
      a.read_allocate_hint = ca[CA_RD_ALLOC];
      a.cacheable = ca[CA_CACHE];
      a.bufferable = ca[CA_BUF];
      return a;
   endfunction

endpackage

// ### verilog/lcp_attr_decode.sv
// attribute decoder: hint bits and attribute classes
`timescale 1ns/1ps
module lcp_attr_decode (
   input wire logic [3:0] cache_i,
   output lcp_pkg::lcp_attr_t attr_o,
   output logic outer_nc_o,
   output logic shared_attr_o,
   output logic wb_attr_o
);
   import lcp_pkg::*;

   always_comb begin
      attr_o = lcp_decode(cache_i);
      // cacheable with no allocate hint is outer non-cacheable
      outer_nc_o = attr_o.cacheable && !attr_o.read_allocate_hint &&
         !attr_o.write_allocate_hint;
      shared_attr_o = (cache_i == ATTR_ONC_A) ||
         (cache_i == ATTR_ONC_B);
      wb_attr_o = (cache_i == ATTR_WB_A) || (cache_i == ATTR_WB_B) ||
         (cache_i == ATTR_WB_C);
   end
endmodule // lcp_attr_decode

// ### verilog/lcp_sec_cfg.sv
// control and auxiliary registers with secure-only writes
`timescale 1ns/1ps
module lcp_sec_cfg (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input lcp_pkg::lcp_cfg_wr_t cfg_i,
   input wire logic lock_we_i,
   input wire logic lock_nonsecure_i,
   output logic ctrl_en_o,
   output logic [31:0] aux_o,
   output logic cfg_refused_o,
   output logic lock_grant_o
);
   import lcp_pkg::*;

   logic ctrl_r, ctrl_nxt, ref_r, ref_nxt, grant_r, grant_nxt;
   logic [31:0] aux_r, aux_nxt;

   always_comb begin
      ctrl_nxt = ctrl_r;
      aux_nxt = aux_r;
      ref_nxt = cfg_i.we && cfg_i.nonsecure;
      grant_nxt = lock_we_i &&
         (!lock_nonsecure_i || aux_r[AUX_LOCK_NONSEC]);
      if (cfg_i.we && !cfg_i.nonsecure) begin
         if (cfg_i.sel_aux) begin
            aux_nxt = cfg_i.wdata;
         end else begin
            ctrl_nxt = cfg_i.wdata[CTRL_EN];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         ctrl_r <= CTRL_RST;
         aux_r <= AUX_RST;
         ref_r <= 1'b0;
         grant_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         aux_r <= aux_nxt;
         ref_r <= ref_nxt;
         grant_r <= grant_nxt;
      end
   end

   assign ctrl_en_o = ctrl_r;
   assign aux_o = aux_r;
   assign cfg_refused_o = ref_r;
   assign lock_grant_o = grant_r;

   property p_nonsec_cfg;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (cfg_i.we && cfg_i.nonsecure) |=>
         $stable(aux_r) && $stable(ctrl_r) && cfg_refused_o;
   endproperty
   a_nonsec_cfg: assert property (p_nonsec_cfg)
      else $error("non-secure write changed a control register");

   property p_lock_gate;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (lock_we_i && lock_nonsecure_i && !aux_r[AUX_LOCK_NONSEC]) |=>
         !lock_grant_o;
   endproperty
   a_lock_gate: assert property (p_lock_gate)
      else $error("non-secure lockdown write granted while disabled");
endmodule // lcp_sec_cfg

// ### verif/lcp_next_level_model.sv
// next level memory model answering security linefills
`timescale 1ns/1ps
module lcp_next_level_model (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic fill_req_i,
   input wire logic [3:0] delay_i,
   input wire logic err_i,
   output logic done_o,
   output logic sec_err_o
);
   logic busy = 1'b0;
   logic [3:0] cnt = 4'h0;
   initial done_o = 1'b0;
   initial sec_err_o = 1'b0;
   always @(posedge core_clk_i) begin
      done_o <= 1'b0;
      // error line carries no meaning outside done
      sec_err_o <= ~sec_err_o;
      if (!rstn_i) begin
         busy <= 1'b0;
      end else if (busy) begin
         if (cnt == 4'h0) begin
            done_o <= 1'b1;
            sec_err_o <= err_i;
            busy <= 1'b0;
         end else begin
            cnt <= cnt - 4'h1;
         end
      end else if (fill_req_i) begin
         busy <= 1'b1;
         cnt <= delay_i;
      end
   end
endmodule // lcp_next_level_model

// ### verif/lcp_policy_tb_top.sv
// testbench for the cache attribute policy block
`timescale 1ns/1ps
module lcp_policy_tb_top;
   import lcp_pkg::*;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   lcp_req_t req_i = '0;
   lcp_look_t look_i = '0;
   lcp_cfg_wr_t cfg_i = '0;
   logic lock_we_i = 1'b0;
   logic lock_ns = 1'b0;
   logic maint_valid_i = 1'b0;
   logic maint_line_ns = 1'b0;
   logic done, serr, perr = 1'b0;
   logic [3:0] pdly = 4'h0;
   logic req_ready_o, fill_req_o, resp_done_o, resp_err_o;
   logic maint_act_o, ctrl_en_o, cfg_refused_o, lock_grant_o;
   lcp_pol_t pol_o;
   logic [3:0] dn_cache_o;
   logic [31:0] aux_o;
   int failures = 0;
   int cmp_count = 0;
   always #5 core_clk_i = ~core_clk_i;
   lcp_policy i_lcp_policy (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .req_i(req_i), .look_i(look_i), .cfg_i(cfg_i),
      .lock_we_i(lock_we_i), .lock_nonsecure_i(lock_ns),
      .maint_valid_i(maint_valid_i), .maint_nonsecure_i(lock_ns),
      .maint_line_nonsecure_i(maint_line_ns),
      .next_level_done_i(done), .next_level_sec_err_i(serr),
      .req_ready_o(req_ready_o), .pol_o(pol_o), .dn_cache_o(dn_cache_o),
      .fill_req_o(fill_req_o), .resp_done_o(resp_done_o),
      .resp_err_o(resp_err_o), .maint_act_o(maint_act_o),
      .ctrl_en_o(ctrl_en_o), .aux_o(aux_o),
      .cfg_refused_o(cfg_refused_o), .lock_grant_o(lock_grant_o));
   lcp_next_level_model i_lcp_next_level_model (.core_clk_i(core_clk_i),
      .rstn_i(rstn_i), .fill_req_i(fill_req_o), .delay_i(pdly),
      .err_i(perr), .done_o(done), .sec_err_o(serr));
   task automatic chk(input logic [31:0] got, exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one request with its lookup, policy checked a cycle later
   task automatic rq(input logic w, input logic [3:0] c,
      input logic sh, ev, cl, ns, hit, tns, dty, input logic [1:0] bst);
      @(posedge core_clk_i);
      req_i <= '{1'b1, w, c, sh, ev, cl, ns, bst, LINE_LEN, LINE_SIZE, 1'b1};
      look_i <= '{hit, tns, dty};
      @(posedge core_clk_i);
      req_i.valid <= 1'b0;
      look_i <= ~look_i;
      #1;
      chk(pol_o.valid, 1, "valid");
      chk(dn_cache_o, c, "dn cache");
   endtask
   task automatic cf(input logic sel, ns, input logic [31:0] d);
      @(posedge core_clk_i);
      cfg_i <= '{1'b1, sel, ns, d};
      @(posedge core_clk_i);
      cfg_i.we <= 1'b0;
      #1;
      chk(cfg_refused_o, ns, "refused");
   endtask
   task automatic side(input logic ns, line_ns, input logic g, a);
      @(posedge core_clk_i);
      lock_we_i <= 1'b1;
      maint_valid_i <= 1'b1;
      lock_ns <= ns;
      maint_line_ns <= line_ns;
      @(posedge core_clk_i);
      lock_we_i <= 1'b0;
      maint_valid_i <= 1'b0;
      #1;
      chk(lock_grant_o, g, "grant");
      chk(maint_act_o, a, "maint");
   endtask
   initial begin
      #100000;
      failures++;
      summarize();
   end
   initial begin
      int n;
      repeat (10) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      #1;
      chk(req_ready_o, 1, "rst ready");
      chk(ctrl_en_o, 0, "rst en");
      chk(aux_o, 0, "rst aux");
      $display("test reset done");
      cf(1, 1, 32'hffff_ffff);
      chk(aux_o, 0, "ns aux");
      cf(0, 0, 32'h1);
      chk(ctrl_en_o, 1, "en");
      cf(0, 1, 32'h0);
      chk(ctrl_en_o, 1, "ns en");
      $display("test config done");
      rq(0, 4'h0, 0, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.bypass, 1, "bypass");
      for (int c = 2; c < 4; c++) begin
         rq(0, c[3:0], 0, 0, 0, 0, 0, 0, 0, 2'h1);
         chk(pol_o.allocate, 0, "onc rd");
         rq(1, c[3:0], 0, 0, 0, 0, 0, 0, 0, 2'h1);
         chk(pol_o.allocate, 0, "onc wr");
      end
      rq(0, 4'h6, 0, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.allocate, 1, "ra rd");
      rq(1, 4'h7, 0, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.allocate, 0, "wb no wa");
      rq(1, 4'hf, 0, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.allocate, 1, "wa wr");
      chk(pol_o.store_buf, 1, "sbuf");
      rq(0, 4'hf, 0, 0, 0, 0, 0, 0, 0, BURST_FIXED);
      chk(pol_o.unpredictable, 1, "fixed");
      $display("test decode done");
      rq(1, 4'h2, 1, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.write_thru, 1, "sh wt");
      chk(pol_o.allocate, 0, "sh wa");
      rq(0, 4'h3, 1, 0, 0, 0, 0, 0, 0, 2'h1);
      chk({pol_o.bypass, pol_o.allocate}, 0, "sh rd");
      rq(1, 4'hb, 1, 0, 0, 0, 0, 0, 0, 2'h1);
      chk({pol_o.write_thru, pol_o.allocate}, 0, "sh ign");
      cf(1, 0, 32'h2000);
      rq(1, 4'h3, 1, 0, 0, 0, 1, 0, 1, 2'h1);
      chk({pol_o.invalidate, pol_o.fwd_next}, 3, "sh inv");
      cf(1, 0, 32'h0040_2000);
      rq(1, 4'h3, 1, 0, 0, 0, 1, 0, 1, 2'h1);
      chk({pol_o.invalidate, pol_o.write_thru}, 0, "sh ovr");
      $display("test shared done");
      cf(1, 0, 32'h0080_0000);
      rq(1, 4'hf, 0, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.allocate, 0, "fwa 01");
      cf(1, 0, 32'h0100_0000);
      rq(1, 4'h3, 0, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.allocate, 1, "fwa 10");
      rq(1, 4'h3, 1, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.allocate, 0, "fwa sh");
      $display("test force done");
      cf(1, 0, 32'h1000);
      rq(0, 4'hf, 0, 0, 0, 0, 1, 0, 1, 2'h1);
      chk({pol_o.clear_valid, pol_o.prefer_evict}, 3, "ex rd");
      rq(0, 4'hf, 0, 0, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.allocate, 0, "ex miss");
      rq(0, 4'h6, 0, 0, 0, 0, 1, 0, 1, 2'h1);
      chk(pol_o.clear_valid, 0, "ex attr");
      rq(1, 4'h7, 0, 1, 1, 0, 1, 0, 0, 2'h1);
      chk(pol_o.set_dirty, 0, "ex clean");
      rq(1, 4'h7, 0, 0, 0, 0, 1, 0, 0, 2'h1);
      chk(pol_o.set_dirty, 1, "ex dirty");
      for (int k = 0; k < 2; k++) begin
         rq(1, 4'h7, 0, 1, k[0], 0, 0, 0, 0, 2'h1);
         chk({pol_o.allocate, pol_o.alloc_dirty}, 3 - k, "ex evict");
      end
      cf(1, 0, 32'h0080_1000);
      rq(1, 4'h7, 0, 1, 0, 0, 0, 0, 0, 2'h1);
      chk(pol_o.allocate, 0, "ex fwa");
      $display("test exclusive done");
      cf(1, 0, 32'h0);
      rq(1, 4'hf, 0, 0, 0, 1, 1, 0, 0, 2'h1);
      chk({pol_o.hit, pol_o.tag_nonsecure}, 1, "ns wr");
      rq(0, 4'hf, 0, 0, 0, 1, 1, 1, 0, 2'h1);
      chk(pol_o.hit, 1, "ns match");
      for (int e = 0; e < 2; e++) begin
         perr <= e[0];
         pdly <= e[0] ? 4'h1 : 4'h6;
         rq(0, 4'hf, 0, 0, 0, 1, 1, 0, 0, 2'h1);
         chk({pol_o.sec_miss, pol_o.hit}, 2, "sec miss");
         chk({pol_o.allocate, pol_o.fwd_next}, 1, "sec fill");
         chk({fill_req_o, req_ready_o}, 2, "fill");
         n = 0;
         while (resp_done_o !== 1'b1 && n < 40) begin
            @(posedge core_clk_i);
            #1;
            n++;
         end
         chk(resp_done_o, 1, "done");
         chk(resp_err_o, e, "err");
         chk(req_ready_o, 1, "ready");
      end
      $display("test security done");
      side(1, 0, 0, 0);
      side(1, 1, 0, 1);
      side(0, 0, 1, 1);
      cf(1, 1, 32'h0400_0000);
      side(1, 0, 0, 0);
      cf(1, 0, 32'h0400_0000);
      side(1, 1, 1, 1);
      $display("test lockdown done");
      summarize();
   end
endmodule // lcp_policy_tb_top
